// ---- hw/ebcs_top.sv ----
// external bus cycle sequencer with axi4-lite registers
// Operation
// - five phases in fixed order per cycle
// - phase lengths come from window timing config
// - ready input may stretch access phase
// - address setup 1-2, plus 0-3 on window change
// - command 0-3, wdata 0-1, access 1-32, hold 0-3; sequencer gives command 1-4, wdata 1-2, hold 1-4
// - shared or separate address/data bus modes
// - read data captured at strobe-release edge
// - phases counted in cpu clock periods
// - inactive ready inserts waitstate, active ends cycle
// - ready polarity and sync/async selectable
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "ebcs_consts.svh"
module ebcs_top
    import ebcs_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [31:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [31:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [23:0] bus_addr_out,
    output logic [3:0] chip_select_n_out,
    output logic read_strobe_n_out,
    output logic write_strobe_n_out,
    output logic addr_latch_enable_out,
    output logic upper_byte_enable_n_out,
    output logic [15:0] bus_data_out,
    output logic bus_data_oe_out,
    input wire logic [15:0] bus_data_in,
    input wire logic ready_in,
    output logic bus_reference_clock_out
);
    logic [31:0] ctrl;
    logic [31:0] req;
    logic [31:0] wdata;
    logic [31:0] win_base [`EBCS_NWIN];
    logic [31:0] window_timing_config [`EBCS_NWIN];
    logic go;
    logic aw_held, w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_word;
    ebcs_phase_t phase;
    logic [5:0] cnt;
    logic tick;
    logic half_div;
    logic [1:0] cur_win;
    logic [1:0] last_win;
    logic last_valid;
    logic [31:0] tim;
    logic [1:0] next_win;
    logic rdy_s1, rdy_s2, rdy_s3;
    logic rdy_seen;
    logic busy;
    logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
    logic [15:0] buf_in_data, buf_out_data;
    logic [31:0] rd_word;

    // cpu clock period tick: every clock or every other clock
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) half_div <= 1'b0;
        else half_div <= ~half_div;
    end
    assign tick = ctrl[`EBCS_C_HALF] ? half_div : 1'b1;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) bus_reference_clock_out <= 1'b0;
        else bus_reference_clock_out <= ctrl[`EBCS_C_REFEN] && (ctrl[`EBCS_C_HALF] ? half_div : ~bus_reference_clock_out);
    end

    // window decode: highest-numbered window whose base is at or below the request address wins
    always_comb begin
        next_win = 2'h0;
        for (int i = 0; i < `EBCS_NWIN; i++) begin
            if (req[23:0] >= win_base[i][23:0]) next_win = 2'(i);
        end
    end
    assign tim = window_timing_config[cur_win];

    // ready: two flops always, third stage in async mode, then polarity
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdy_s1 <= 1'b0;
            rdy_s2 <= 1'b0;
            rdy_s3 <= 1'b0;
        end else begin
            rdy_s1 <= ready_in;
            rdy_s2 <= rdy_s1;
            rdy_s3 <= rdy_s2;
        end
    end
    assign rdy_seen = (tim[`EBCS_F_RDYASYNC] ? rdy_s3 : rdy_s2) ^ ~tim[`EBCS_F_RDYPOL];

    // phase sequencer
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase <= EBCS_IDLE;
            cnt <= 6'h00;
            cur_win <= 2'h0;
            last_win <= 2'h0;
            last_valid <= 1'b0;
        end else if (phase == EBCS_IDLE) begin
            if (go) begin
                cur_win <= next_win;
                phase <= EBCS_AB;
                cnt <= 6'h00;
            end
        end else if (tick) begin
            cnt <= cnt + 6'h01;
            unique case (phase)
                EBCS_AB: begin
                    if (cnt >= {5'h00, tim[`EBCS_F_AB]}
                        + ((last_valid && last_win != cur_win)
                           ? {4'h0, tim[`EBCS_F_ABX+1:`EBCS_F_ABX]} : 6'h00)) begin
                        phase <= EBCS_C;
                        cnt <= 6'h00;
                    end
                end
                EBCS_C: if (cnt >= {4'h0, tim[`EBCS_F_C+1:`EBCS_F_C]}) begin
                    phase <= EBCS_D;
                    cnt <= 6'h00;
                end
                EBCS_D: if (cnt >= {5'h00, tim[`EBCS_F_D]}) begin
                    phase <= EBCS_E;
                    cnt <= 6'h00;
                end
                // a read leaves access only with buffer room for its word
                EBCS_E: if (cnt >= {1'b0, tim[`EBCS_F_E+4:`EBCS_F_E]}
                            && (req[`EBCS_R_WRITE] || buf_in_ready)) begin
                    phase <= tim[`EBCS_F_RDYEN] ? EBCS_RDY : EBCS_F;
                    cnt <= 6'h00;
                end
                EBCS_RDY: if (rdy_seen && (req[`EBCS_R_WRITE] || buf_in_ready)) begin
                    phase <= EBCS_F;
                    cnt <= 6'h00;
                end
                EBCS_F: if (cnt >= {4'h0, tim[`EBCS_F_F+1:`EBCS_F_F]}) begin
                    phase <= EBCS_IDLE;
                    last_win <= cur_win;
                    last_valid <= 1'b1;
                end
                default: phase <= EBCS_IDLE;
            endcase
        end
    end
    assign busy = (phase != EBCS_IDLE);

    // bus pins
    logic in_cmd;
    logic is_wr;
    logic shared_addr_data_mode;
    assign in_cmd = (phase == EBCS_E) || (phase == EBCS_RDY);
    assign is_wr = req[`EBCS_R_WRITE];
    assign shared_addr_data_mode = tim[`EBCS_F_MUX];
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bus_addr_out <= 24'h00_0000;
            chip_select_n_out <= 4'hF;
            read_strobe_n_out <= 1'b1;
            write_strobe_n_out <= 1'b1;
            addr_latch_enable_out <= 1'b0;
            upper_byte_enable_n_out <= 1'b1;
            bus_data_out <= 16'h0000;
            bus_data_oe_out <= 1'b0;
        end else begin
            bus_addr_out <= busy ? req[23:0] : bus_addr_out;
            chip_select_n_out <= busy ? ~(4'h1 << cur_win) : 4'hF;
            read_strobe_n_out <= ~(in_cmd && !is_wr);
            write_strobe_n_out <= ~(in_cmd && is_wr);
            addr_latch_enable_out <= (phase == EBCS_AB) && shared_addr_data_mode;
            upper_byte_enable_n_out <= ~busy;
            // shared lines carry address in setup, float in turnaround
            bus_data_out <= (shared_addr_data_mode && phase == EBCS_AB) ? req[15:0] : wdata[15:0];
            bus_data_oe_out <= (shared_addr_data_mode && phase == EBCS_AB) ||
                               (is_wr && (phase == EBCS_D || in_cmd || phase == EBCS_F)
                                && !(shared_addr_data_mode && phase == EBCS_D));
        end
    end

    // capture read data on the edge that ends the strobe
    // strobe low now and released at this edge
    assign buf_in_valid = !read_strobe_n_out && !in_cmd;
    assign buf_in_data = bus_data_in;
    assign buf_out_ready = s_axi_arvalid_in && s_axi_arready_out
                           && s_axi_araddr_in == `EBCS_ADDR_RDATA;

    ebcs_buf u_buf (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .in_data_in(buf_in_data),
        .in_valid_in(buf_in_valid),
        .in_ready_out(buf_in_ready),
        .out_data_out(buf_out_data),
        .out_valid_out(buf_out_valid),
        .out_ready_in(buf_out_ready)
    );

    // axi4-lite write side
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_word <= 32'h0000_0000;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `EBCS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_held <= 1'b1;
                w_word <= s_axi_wdata_in;
            end
            if (aw_held && w_held && !s_axi_bvalid_out) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= ((aw_addr <= `EBCS_ADDR_WDATA) ||
                    (aw_addr >= `EBCS_ADDR_WIN0 && aw_addr <= `EBCS_ADDR_TIM_LAST))
                    ? `EBCS_RESP_OKAY : `EBCS_RESP_SLVERR;
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end
    assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
    assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;

    logic do_wr;
    assign do_wr = aw_held && w_held && !s_axi_bvalid_out;
    // registers; a request write while busy is dropped
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl <= `EBCS_CTRL_RESET;
            req <= 32'h0000_0000;
            wdata <= 32'h0000_0000;
            go <= 1'b0;
            for (int i = 0; i < `EBCS_NWIN; i++) begin
                win_base[i] <= `EBCS_WIN_RESET;
                window_timing_config[i] <= `EBCS_TIM_RESET;
            end
        end else begin
            if (phase == EBCS_IDLE && go) go <= 1'b0;
            if (do_wr) begin
                if (aw_addr == `EBCS_ADDR_CTRL) ctrl <= w_word;
                if (aw_addr == `EBCS_ADDR_WDATA) wdata <= w_word;
                if (aw_addr == `EBCS_ADDR_REQ && !busy && !go) begin
                    req <= w_word;
                    go <= 1'b1;
                end
                for (int i = 0; i < `EBCS_NWIN; i++) begin
                    if (aw_addr == `EBCS_ADDR_WIN0 + 32'(4 * i)) win_base[i] <= w_word;
                    if (aw_addr == `EBCS_ADDR_TIM0 + 32'(4 * i)) window_timing_config[i] <= w_word;
                end
            end
        end
    end

    // axi4-lite read side
    always_comb begin
        rd_word = 32'h0000_0000;
        if (s_axi_araddr_in == `EBCS_ADDR_CTRL) rd_word = ctrl;
        if (s_axi_araddr_in == `EBCS_ADDR_REQ) rd_word = req;
        if (s_axi_araddr_in == `EBCS_ADDR_WDATA) rd_word = wdata;
        if (s_axi_araddr_in == `EBCS_ADDR_STATUS)
            rd_word = {25'h000_0000, phase, buf_out_valid, go, busy || go};
        if (s_axi_araddr_in == `EBCS_ADDR_RDATA) rd_word = {15'h0000, buf_out_valid, buf_out_data};
        for (int i = 0; i < `EBCS_NWIN; i++) begin
            if (s_axi_araddr_in == `EBCS_ADDR_WIN0 + 32'(4 * i)) rd_word = win_base[i];
            if (s_axi_araddr_in == `EBCS_ADDR_TIM0 + 32'(4 * i)) rd_word = window_timing_config[i];
        end
    end
    assign s_axi_arready_out = !s_axi_rvalid_out;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= `EBCS_RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_word;
            s_axi_rresp_out <= ((s_axi_araddr_in <= `EBCS_ADDR_RDATA) ||
                (s_axi_araddr_in >= `EBCS_ADDR_WIN0 && s_axi_araddr_in <= `EBCS_ADDR_TIM_LAST))
                ? `EBCS_RESP_OKAY : `EBCS_RESP_SLVERR;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end
endmodule

// ---- hw/ebcs_consts.svh ----
// constants for the external bus cycle sequencer
`ifndef EBCS_CONSTS_SVH
`define EBCS_CONSTS_SVH
`define EBCS_ADDR_CTRL 32'h0000_0000
`define EBCS_ADDR_REQ 32'h0000_0004
`define EBCS_ADDR_WDATA 32'h0000_0008
`define EBCS_ADDR_STATUS 32'h0000_000C
`define EBCS_ADDR_RDATA 32'h0000_0010
`define EBCS_ADDR_WIN0 32'h0000_0020
`define EBCS_ADDR_WIN_LAST 32'h0000_002C
`define EBCS_ADDR_TIM0 32'h0000_0030
`define EBCS_ADDR_TIM_LAST 32'h0000_003C
`define EBCS_RESP_OKAY 2'h0
`define EBCS_RESP_SLVERR 2'h2
`define EBCS_NWIN 4
`define EBCS_TIM_RESET 32'h0000_0000
`define EBCS_WIN_RESET 32'h0000_0000
`define EBCS_CTRL_RESET 32'h0000_0000
// timing word fields
`define EBCS_F_AB 0
`define EBCS_F_ABX 1
`define EBCS_F_C 3
`define EBCS_F_D 5
`define EBCS_F_E 6
`define EBCS_F_F 11
`define EBCS_F_RDYEN 13
`define EBCS_F_RDYPOL 14
`define EBCS_F_RDYASYNC 15
`define EBCS_F_MUX 16
// ctrl fields
`define EBCS_C_HALF 0
`define EBCS_C_REFEN 1
// request fields
`define EBCS_R_WRITE 24
`endif

// ---- hw/ebcs_pkg.sv ----
// types for the external bus cycle sequencer
package ebcs_pkg;
    typedef enum logic [2:0] {
        EBCS_IDLE,
        EBCS_AB,
        EBCS_C,
        EBCS_D,
        EBCS_E,
        EBCS_RDY,
        EBCS_F
    } ebcs_phase_t;
endpackage

// ---- hw/ebcs_buf.sv ----
// two-entry valid/ready buffer for read data
`timescale 1ns/100ps
module ebcs_buf
    import ebcs_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [15:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [15:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    logic [15:0] mem [2];
    logic wptr;
    logic rptr;
    logic [1:0] count;
    logic push;
    logic pop;

    assign in_ready_out = (count != 2'h2);
    assign out_valid_out = (count != 2'h0);
    assign out_data_out = mem[rptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mem[0] <= 16'h0000;
            mem[1] <= 16'h0000;
        end else if (push) begin
            mem[wptr] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wptr <= 1'b0;
            rptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) wptr <= ~wptr;
            if (pop) rptr <= ~rptr;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ---- sim/ebcs_props.sv ----
// assertions on the sequencer pins and axi read channel
`timescale 1ns/100ps
module ebcs_props (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [23:0] bus_addr_out,
    input wire logic [3:0] chip_select_n_out,
    input wire logic read_strobe_n_out,
    input wire logic write_strobe_n_out,
    input wire logic addr_latch_enable_out,
    input wire logic upper_byte_enable_n_out,
    input wire logic bus_data_oe_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire cmd = !read_strobe_n_out || !write_strobe_n_out;
    sequence s_wr_release;
        $rose(write_strobe_n_out);
    endsequence
    sequence s_in_access;
        cmd ##1 cmd;
    endsequence
    a_strobe_excl: assert property (read_strobe_n_out || write_strobe_n_out)
        else $error("both strobes low");
    a_addr_steady: assert property (s_in_access |-> $stable(bus_addr_out)
        && $stable(chip_select_n_out))
        else $error("address moved in access");
    a_ale_no_cmd: assert property (addr_latch_enable_out |-> !cmd)
        else $error("latch enable during command");
    a_cs_onehot: assert property (cmd |-> $onehot(~chip_select_n_out))
        else $error("select not one-hot");
    a_read_float: assert property (!read_strobe_n_out |-> !bus_data_oe_out)
        else $error("driving data in read");
    a_write_drive: assert property (!write_strobe_n_out |-> bus_data_oe_out)
        else $error("write data not driven");
    a_wdata_hold: assert property (s_wr_release |-> bus_data_oe_out
        && $stable(bus_addr_out))
        else $error("hold phase lost");
    a_ube_cycle: assert property (cmd |-> !upper_byte_enable_n_out)
        else $error("byte enable idle in access");
    a_rvalid_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
        s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read answer dropped");
endmodule
bind ebcs_top ebcs_props i_props (.clk_in, .rst_in, .s_axi_rvalid_out, .s_axi_rready_in,
    .s_axi_rdata_out, .bus_addr_out, .chip_select_n_out, .read_strobe_n_out,
    .write_strobe_n_out, .addr_latch_enable_out, .upper_byte_enable_n_out, .bus_data_oe_out);

// ---- sim/ebcs_mem.sv ----
// behavioural external memory with programmable ready delay
`timescale 1ns/100ps
module ebcs_mem (
    input wire logic clk_in,
    input wire logic [23:0] addr_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic ale_in,
    input wire logic shared_in,
    input wire logic [15:0] data_in,
    input wire logic [3:0] delay_in,
    input wire logic pol_in,
    output logic [15:0] data_out,
    output logic ready_out
);
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0000;
    logic [3:0] cnt = 4'h0;
    logic [3:0] low_addr = 4'h0;
    wire act = !rd_n_in || !wr_n_in;
    wire [3:0] idx = shared_in ? low_addr : addr_in[3:0];
    // memory word only while the read strobe is low, toggling garbage otherwise
    assign data_out = !rd_n_in ? mem[idx] : ~last;
    assign ready_out = (act && cnt >= delay_in) == pol_in;
    always @(posedge clk_in) begin
        last <= data_out;
        cnt <= act ? cnt + 4'(cnt != 4'hF) : 4'h0;
        if (ale_in) low_addr <= data_in[3:0];
        if (!wr_n_in) mem[idx] <= data_in;
    end
endmodule

// ---- sim/ebcs_top_test.sv ----
// self-checking bench for the bus cycle sequencer
`timescale 1ns/100ps
`include "ebcs_consts.svh"
module ebcs_top_test;
    logic clk_in = 1'b0, rst_in = 1'b1;
    logic [31:0] s_axi_awaddr_in = 32'h0, s_axi_wdata_in = 32'h0, s_axi_araddr_in = 32'h0;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out, read_strobe_n_out, write_strobe_n_out, addr_latch_enable_out;
    logic upper_byte_enable_n_out, bus_data_oe_out, bus_reference_clock_out, ready_in;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic [31:0] s_axi_rdata_out;
    logic [23:0] bus_addr_out;
    logic [3:0] chip_select_n_out, rdy_delay = 4'h0;
    logic [15:0] bus_data_out, bus_data_in;
    logic rdy_pol = 1'b1, shared_mode = 1'b0, armed = 1'b1;
    int err_count = 0, check_count = 0, cyc = 0, pre = 0, low = 0;
    ebcs_top i_dut (.*);
    ebcs_mem i_mem (.clk_in(clk_in), .addr_in(bus_addr_out), .rd_n_in(read_strobe_n_out),
        .wr_n_in(write_strobe_n_out), .ale_in(addr_latch_enable_out), .shared_in(shared_mode),
        .data_in(bus_data_out), .delay_in(rdy_delay), .pol_in(rdy_pol),
        .data_out(bus_data_in), .ready_out(ready_in));
    initial forever #5 clk_in = ~clk_in;
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            wrap_up();
        end
    end
    // setup and strobe-low lengths of the latest bus cycle
    always @(posedge clk_in) begin
        if (chip_select_n_out == 4'hF) begin
            armed <= 1'b1;
        end else if (armed) begin
            armed <= 1'b0;
            pre <= 1;
            low <= 0;
        end else if (!read_strobe_n_out || !write_strobe_n_out) begin
            low <= low + 1;
        end else if (low == 0) begin
            pre <= pre + 1;
        end
    end
    task automatic check(input logic [31:0] got, exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic axw(input logic [31:0] a, d, output logic [1:0] r);
        @(posedge clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        do begin
            @(posedge clk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (s_axi_bvalid_out !== 1'b1);
        r = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
    endtask
    task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        do @(posedge clk_in); while (s_axi_arready_out !== 1'b1);
        s_axi_arvalid_in <= 1'b0;
        do @(posedge clk_in); while (s_axi_rvalid_out !== 1'b1);
        s_axi_rready_in <= 1'b1;
        do @(posedge clk_in); while (s_axi_rvalid_out !== 1'b1);
        d = s_axi_rdata_out;
        r = s_axi_rresp_out;
        s_axi_rready_in <= 1'b0;
    endtask
    task automatic idle(input int tries, output logic [31:0] s);
        logic [1:0] r;
        s = 32'h1;
        for (int k = 0; k < tries && s[1:0] != 2'h0; k++) axr(`EBCS_ADDR_STATUS, s, r);
    endtask
    initial begin
        logic [31:0] tim, s, d;
        logic [23:0] a;
        logic [1:0] r;
        logic [15:0] exp [16];
        int per, x, prev;
        void'($urandom(32'hd1db82c6));
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        axr(`EBCS_ADDR_TIM0, d, r);
        check(d, `EBCS_TIM_RESET, "timing reset");
        axr(32'h0000_0100, d, r);
        check(32'(r), 32'(`EBCS_RESP_SLVERR), "unmapped read");
        axw(32'h0000_0104, 32'h1, r);
        check(32'(r), 32'(`EBCS_RESP_SLVERR), "unmapped write");
        for (int i = 0; i < 4; i++) axw(`EBCS_ADDR_WIN0 + 32'(4 * i), 32'(i) << 22, r);
        prev = 0;
        for (int i = 0; i < 12; i++) begin
            s = $urandom & 32'h3;
            per = s[0] ? 2 : 1;
            axw(`EBCS_ADDR_CTRL, s, r);
            a = 24'($urandom & 32'hFFFFF0) | 24'(i);
            tim = $urandom & 32'h1_F9FF;
            x = (i > 0 && a[23:22] != prev) ? tim[2:1] : 0;
            axw(`EBCS_ADDR_TIM0 + 32'(4 * a[23:22]), tim, r);
            rdy_delay <= 4'($urandom);
            rdy_pol <= tim[14];
            shared_mode <= tim[16];
            d = $urandom & 32'hFFFF;
            exp[i] = d[15:0];
            axw(`EBCS_ADDR_WDATA, d, r);
            axw(`EBCS_ADDR_REQ, {7'h0, 1'b1, a}, r);
            idle(50, s);
            check(32'(pre >= per * (1 + tim[0] + x + tim[4:3] + tim[5])), 1, "setup");
            check(32'(low >= per * (tim[10:6] + 1) && (!tim[13] || low >= rdy_delay)), 1,
                "access");
            axw(`EBCS_ADDR_REQ, {8'h0, a}, r);
            idle(50, s);
            axr(`EBCS_ADDR_RDATA, d, r);
            check(d, {15'h0, 1'b1, exp[i]}, "read back");
            prev = a[23:22];
        end
        // low addresses fall in window 0: plain separate-bus timing
        axw(`EBCS_ADDR_TIM0, 32'h0, r);
        shared_mode <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            axw(`EBCS_ADDR_REQ, 32'(k), r);
            idle(k < 2 ? 50 : 12, s);
        end
        check(32'(s[0]), 1, "stall on full buffer");
        for (int k = 0; k < 4; k++) begin
            axr(`EBCS_ADDR_RDATA, d, r);
            if (k < 3) check(d, {15'h0, 1'b1, exp[k]}, "buffer drain");
            else check(32'(d[16]), 0, "buffer empty");
            if (k == 1) idle(50, s);
        end
        wrap_up();
    end
endmodule
